// *** hw/clock_power_control.sv ***
`timescale 1ns/1ns
module clock_power_control
    import clock_power_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic WAKE_EVENT,
    input wire logic FLASH_RD_IN,
    output logic FLASH_RD_OUT,
    output logic FAST_OSC_EN,
    output logic PLL_EN,
    output logic SLOW_OSC_EN,
    output logic ANALOG_REF_EN,
    output logic REGULATOR_EN,
    output logic USB_XCVR_EN,
    output logic USB_PULLUP_EN,
    output logic [4:0] PLL_FACTOR,
    output logic BAUD_DOUBLE,
    output logic CPU_STOP,
    output logic CPU_IDLE,
    output logic KEYPAD_CLK,
    output logic CARD_CLK,
    output logic USB_CLK
);
    state_t r;
    state_t s;
    logic [15:0] widx;
    logic [15:0] ridx;
    logic [2:0] fwidth;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s = r;
        widx = r.waddr[ADDR_W-1:2];
        ridx = ARADDR[ADDR_W-1:2];
        fwidth = r.regs.power_options_second[LONG_READ_PULSE_SELECT_BIT] ?
            3'(FLASH_LONG_CYC) : 3'(FLASH_SHORT_CYC);

        // A wake event leaves stop, idle and power-down; a write in the same
        // cycle comes after it and therefore wins.
        if (WAKE_EVENT) begin
            s.regs.cpu_power_mode[CPU_STOP_BIT] = 1'b0;
            s.regs.cpu_power_mode[CPU_IDLE_BIT] = 1'b0;
            s.regs.power_options_first[POWER_DOWN_REQUEST_BIT] = 1'b0;
        end

        if (BREADY && r.bvalid) begin
            s.bvalid = 1'b0;
        end
        if (AWVALID && r.aw_rdy) begin
            s.aw_got = 1'b1;
            s.waddr = AWADDR;
        end
        if (WVALID && r.w_rdy) begin
            s.w_got = 1'b1;
            s.wdata = WDATA[7:0];
            s.wstb = WSTRB[0];
        end
        if (s.aw_got && s.w_got && !r.bvalid) begin
            widx = s.waddr[ADDR_W-1:2];
            s.aw_got = 1'b0;
            s.w_got = 1'b0;
            s.bvalid = 1'b1;
            s.bresp = RESP_OKAY;
            if (widx == CPU_POWER_MODE_IDX) begin
                if (s.wstb) begin
                    s.regs.cpu_power_mode = s.wdata & CPU_POWER_MODE_MASK;
                end
            end else if (widx == MASTER_CLOCK_GATING_IDX) begin
                if (s.wstb) begin
                    s.regs.master_clock_gating = s.wdata;
                end
            end else if (widx == POWER_OPTIONS_FIRST_IDX) begin
                if (s.wstb) begin
                    s.regs.power_options_first = s.wdata & POWER_OPTIONS_FIRST_MASK;
                end
            end else if (widx == POWER_OPTIONS_SECOND_IDX) begin
                if (s.wstb) begin
                    s.regs.power_options_second = s.wdata & POWER_OPTIONS_SECOND_MASK;
                end
            end else begin
                s.bresp = RESP_SLVERR;
            end
        end

        if (RREADY && r.rvalid) begin
            s.rvalid = 1'b0;
        end
        if (ARVALID && r.ar_rdy) begin
            s.rvalid = 1'b1;
            s.rresp = RESP_OKAY;
            if (ridx == CPU_POWER_MODE_IDX) begin
                s.rdata = r.regs.cpu_power_mode;
            end else if (ridx == MASTER_CLOCK_GATING_IDX) begin
                s.rdata = r.regs.master_clock_gating;
            end else if (ridx == POWER_OPTIONS_FIRST_IDX) begin
                s.rdata = r.regs.power_options_first;
            end else if (ridx == POWER_OPTIONS_SECOND_IDX) begin
                s.rdata = r.regs.power_options_second;
            end else begin
                s.rdata = 8'h00;
                s.rresp = RESP_SLVERR;
            end
        end
        s.aw_rdy = !s.aw_got && !s.bvalid;
        s.w_rdy = !s.w_got && !s.bvalid;
        s.ar_rdy = !s.rvalid;

        // -----------------------------------------------------------
        // Power-down delay
        // -----------------------------------------------------------
        // The delay gives the next instruction time to stop the processor
        // before its clock source disappears.
        if (!s.regs.power_options_first[POWER_DOWN_REQUEST_BIT]) begin
            s.pd_cnt = 6'h00;
            s.pd_active = 1'b0;
        end else if (r.regs.power_options_first[POWER_DOWN_REQUEST_BIT] && !r.pd_active) begin
            if (r.pd_cnt == PD_DELAY_CYC - 6'd1) begin
                s.pd_active = 1'b1;
            end else begin
                s.pd_cnt = r.pd_cnt + 6'd1;
            end
        end

        // -----------------------------------------------------------
        // Flash read strobe
        // -----------------------------------------------------------
        s.frd_in_d = FLASH_RD_IN;
        if (r.regs.power_options_second[FLASH_PULSE_BYPASS_BIT]) begin
            s.flash_rd = FLASH_RD_IN;
            s.fst = FLASH_RD_IN ? FR_HOLD : FR_IDLE;
        end else begin
            case (r.fst)
                FR_IDLE: begin
                    if (FLASH_RD_IN && !r.frd_in_d) begin
                        s.flash_rd = 1'b1;
                        s.fcnt = fwidth - 3'd1;
                        s.fst = FR_PULSE;
                    end else begin
                        s.flash_rd = 1'b0;
                    end
                end
                FR_PULSE: begin
                    if (!FLASH_RD_IN) begin
                        s.flash_rd = 1'b0;
                        s.fst = FR_IDLE;
                    end else if (r.fcnt == 3'd0) begin
                        s.flash_rd = 1'b0;
                        s.fst = FR_HOLD;
                    end else begin
                        s.fcnt = r.fcnt - 3'd1;
                    end
                end
                FR_HOLD: begin
                    s.flash_rd = 1'b0;
                    if (!FLASH_RD_IN) begin
                        s.fst = FR_IDLE;
                    end
                end
                default: begin
                    s.flash_rd = 1'b0;
                    s.fst = FR_IDLE;
                end
            endcase
        end

        // -----------------------------------------------------------
        // Output controls
        // -----------------------------------------------------------
        // Power-down overrides the fast oscillator, PLL and unit clock enables without touching the stored bits.
        s.fast_osc_en = !s.regs.master_clock_gating[FAST_OSC_OFF_BIT] && !s.pd_active;
        s.pll_en = s.fast_osc_en && !s.regs.power_options_second[ANALOG_POWER_OFF_BIT];
        s.slow_osc_en = !s.regs.master_clock_gating[SLOW_OSC_OFF_BIT];
        s.analog_en = !s.regs.power_options_second[ANALOG_POWER_OFF_BIT];
        s.regulator_en = !s.regs.power_options_second[ANALOG_POWER_OFF_BIT];
        s.xcvr_en = !s.regs.power_options_second[USB_TRANSCEIVER_OFF_BIT];
        s.pullup_en = s.regs.power_options_second[USB_PULLUP_CONNECT_BIT];
        s.baud_dbl = s.regs.cpu_power_mode[BAUD_DOUBLER_BIT];
        s.cpu_stop = s.regs.cpu_power_mode[CPU_STOP_BIT];
        s.cpu_idle = s.regs.cpu_power_mode[CPU_IDLE_BIT];
        s.pll_factor = {1'b0, s.regs.master_clock_gating[PLL_MULTIPLIER_LSB+:3], 1'b0}
            + PLL_FACTOR_BASE;
        s.kp_run = !s.regs.master_clock_gating[KEYPAD_CLOCK_OFF_BIT] && !s.pd_active;
        s.card_run = !s.regs.master_clock_gating[CARD_CLOCK_OFF_BIT] && !s.pd_active;
        s.usb_run = !s.regs.master_clock_gating[USB_CLOCK_OFF_BIT] && !s.pd_active;
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            r <= '0;
            r.regs.cpu_power_mode <= CPU_POWER_MODE_RST;
            r.regs.master_clock_gating <= MASTER_CLOCK_GATING_RST;
            r.regs.power_options_first <= POWER_OPTIONS_FIRST_RST;
            r.regs.power_options_second <= POWER_OPTIONS_SECOND_RST;
            r.fst <= FR_IDLE;
            r.aw_rdy <= 1'b1;
            r.w_rdy <= 1'b1;
            r.ar_rdy <= 1'b1;
            r.fast_osc_en <= 1'b1;
            r.pll_en <= 1'b1;
            r.analog_en <= 1'b1;
            r.regulator_en <= 1'b1;
            r.xcvr_en <= 1'b1;
            r.pll_factor <= 5'd8;
            r.kp_run <= 1'b1;
            r.card_run <= 1'b1;
            r.usb_run <= 1'b1;
        end else begin
            r <= s;
        end
    end

    // ---------------------------------------------------------------
    // Unit clocks
    // ---------------------------------------------------------------
    // The keypad, card and USB clocks are all gated copies of SYS_CLK;
    // each stops when its off bit is set or power-down is active.
    unit_clock_gate keypad_gate (.clk(SYS_CLK), .rst_n(RESET_N), .run(r.kp_run),
        .gclk(KEYPAD_CLK));
    unit_clock_gate card_gate (.clk(SYS_CLK), .rst_n(RESET_N), .run(r.card_run),
        .gclk(CARD_CLK));
    unit_clock_gate usb_gate (.clk(SYS_CLK), .rst_n(RESET_N), .run(r.usb_run),
        .gclk(USB_CLK));

    assign AWREADY = r.aw_rdy;
    assign WREADY = r.w_rdy;
    assign BVALID = r.bvalid;
    assign BRESP = r.bresp;
    assign ARREADY = r.ar_rdy;
    assign RVALID = r.rvalid;
    assign RDATA = {24'h000000, r.rdata};
    assign RRESP = r.rresp;
    assign FLASH_RD_OUT = r.flash_rd;
    assign FAST_OSC_EN = r.fast_osc_en;
    assign PLL_EN = r.pll_en;
    assign SLOW_OSC_EN = r.slow_osc_en;
    assign ANALOG_REF_EN = r.analog_en;
    assign REGULATOR_EN = r.regulator_en;
    assign USB_XCVR_EN = r.xcvr_en;
    assign USB_PULLUP_EN = r.pullup_en;
    assign PLL_FACTOR = r.pll_factor;
    assign BAUD_DOUBLE = r.baud_dbl;
    assign CPU_STOP = r.cpu_stop;
    assign CPU_IDLE = r.cpu_idle;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    logic [5:0] pd_age_r;
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N || !r.regs.power_options_first[POWER_DOWN_REQUEST_BIT]) begin
            pd_age_r <= 6'h00;
        end else if (pd_age_r != 6'h3F) begin
            pd_age_r <= pd_age_r + 6'd1;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    a_pd_exact_delay: assert property ($rose(r.pd_active) |-> pd_age_r == 6'd32)
        else $error("power-down did not take effect 32 cycles after request");
    a_pd_osc_off: assert property (r.pd_active |-> !FAST_OSC_EN && !PLL_EN)
        else $error("oscillator or PLL running in power-down");
    a_pd_units_off: assert property (r.pd_active |-> !r.kp_run && !r.card_run && !r.usb_run)
        else $error("unit clock still enabled in power-down");
    a_bypass_pass: assert property ($past(r.regs.power_options_second[5])
        |-> FLASH_RD_OUT == $past(FLASH_RD_IN))
        else $error("bypassed flash strobe differs from input");
    a_trim_end: assert property (r.fst == FR_PULSE && r.fcnt == 3'd0 |=> !FLASH_RD_OUT)
        else $error("trimmed flash strobe too long");
    a_trim_long_width: assert property ($rose(FLASH_RD_OUT) && !$past(r.regs.power_options_second[5])
        && $past(r.regs.power_options_second[4]) |-> r.fcnt == 3'(FLASH_LONG_CYC - 1))
        else $error("long trimmed width not selected");
    a_pll_factor: assert property ($changed(r.regs.master_clock_gating[2:0])
        |-> PLL_FACTOR == {1'b0, r.regs.master_clock_gating[2:0], 1'b0} + 5'd4)
        else $error("PLL factor does not follow multiplier");
    a_usb_xcvr: assert property (USB_XCVR_EN != r.regs.power_options_second[1])
        else $error("transceiver enable wrong");
    a_usb_pullup: assert property (USB_PULLUP_EN == r.regs.power_options_second[0])
        else $error("pull-up connect wrong");
    a_slow_osc: assert property (SLOW_OSC_EN != r.regs.master_clock_gating[3])
        else $error("slow oscillator enable wrong");

    c_power_down: cover property ($rose(r.pd_active));
    c_trimmed_pulse: cover property ($fell(FLASH_RD_OUT) && FLASH_RD_IN);
    c_write_done: cover property (BVALID && BREADY && BRESP == RESP_OKAY);
    c_read_done: cover property (RVALID && RREADY);
endmodule

// *** hw/clock_power_pkg.sv ***
package clock_power_pkg;

    // ---------------------------------------------------------------
    // Register map and bus
    // ---------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam logic [15:0] CPU_POWER_MODE_IDX = 16'h0087;
    localparam logic [15:0] MASTER_CLOCK_GATING_IDX = 16'h008F;
    localparam logic [15:0] POWER_OPTIONS_FIRST_IDX = 16'hFFF1;
    localparam logic [15:0] POWER_OPTIONS_SECOND_IDX = 16'hFFF2;
    localparam logic [7:0] CPU_POWER_MODE_RST = 8'h00;
    localparam logic [7:0] MASTER_CLOCK_GATING_RST = 8'h0A;
    localparam logic [7:0] POWER_OPTIONS_FIRST_RST = 8'h00;
    localparam logic [7:0] POWER_OPTIONS_SECOND_RST = 8'h10;
    localparam logic [7:0] CPU_POWER_MODE_MASK = 8'h8F;
    localparam logic [7:0] POWER_OPTIONS_FIRST_MASK = 8'h80;
    localparam logic [7:0] POWER_OPTIONS_SECOND_MASK = 8'h37;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int BAUD_DOUBLER_BIT = 7;
    localparam int CPU_STOP_BIT = 1;
    localparam int CPU_IDLE_BIT = 0;
    localparam int FAST_OSC_OFF_BIT = 7;
    localparam int KEYPAD_CLOCK_OFF_BIT = 6;
    localparam int CARD_CLOCK_OFF_BIT = 5;
    localparam int USB_CLOCK_OFF_BIT = 4;
    localparam int SLOW_OSC_OFF_BIT = 3;
    localparam int PLL_MULTIPLIER_LSB = 0;
    localparam int POWER_DOWN_REQUEST_BIT = 7;
    localparam int FLASH_PULSE_BYPASS_BIT = 5;
    localparam int LONG_READ_PULSE_SELECT_BIT = 4;
    localparam int ANALOG_POWER_OFF_BIT = 2;
    localparam int USB_TRANSCEIVER_OFF_BIT = 1;
    localparam int USB_PULLUP_CONNECT_BIT = 0;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int FLASH_SHORT_NS = 40;
    localparam int FLASH_LONG_NS = 66;
    localparam int FLASH_SHORT_CYC = (FLASH_SHORT_NS / CLK_PERIOD_NS < 1) ? 1 :
        FLASH_SHORT_NS / CLK_PERIOD_NS;
    localparam int FLASH_LONG_CYC = (FLASH_LONG_NS / CLK_PERIOD_NS < 1) ? 1 :
        FLASH_LONG_NS / CLK_PERIOD_NS;
    localparam logic [5:0] PD_DELAY_CYC = 6'd32;
    localparam logic [4:0] PLL_FACTOR_BASE = 5'd4;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        FR_IDLE = 3'b001,
        FR_PULSE = 3'b010,
        FR_HOLD = 3'b100
    } flash_state_t;

    typedef struct packed {
        logic [7:0] cpu_power_mode;
        logic [7:0] master_clock_gating;
        logic [7:0] power_options_first;
        logic [7:0] power_options_second;
    } regs_t;

    typedef struct packed {
        regs_t regs;
        logic [5:0] pd_cnt;
        logic pd_active;
        flash_state_t fst;
        logic [2:0] fcnt;
        logic frd_in_d;
        logic flash_rd;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] waddr;
        logic [7:0] wdata;
        logic wstb;
        logic aw_rdy;
        logic w_rdy;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic fast_osc_en;
        logic pll_en;
        logic slow_osc_en;
        logic analog_en;
        logic regulator_en;
        logic xcvr_en;
        logic pullup_en;
        logic baud_dbl;
        logic cpu_stop;
        logic cpu_idle;
        logic [4:0] pll_factor;
        logic kp_run;
        logic card_run;
        logic usb_run;
    } state_t;

endpackage

// *** hw/unit_clock_gate.sv ***
`timescale 1ns/1ns
module unit_clock_gate (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic gclk
);
    logic run_low_r;

    // The enable is retimed on the falling edge, while the clock is low,
    // so the AND below can never clip a high phase into a runt pulse.
    always_ff @(negedge clk) begin
        if (!rst_n) begin
            run_low_r <= 1'b0;
        end else begin
            run_low_r <= run;
        end
    end

    assign gclk = clk & run_low_r;
endmodule

// *** testbench/clock_power_control_tb.sv ***
`timescale 1ns/1ns
module clock_power_control_tb
    import clock_power_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic SYS_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic [ADDR_W-1:0] AWADDR = '0;
    logic [ADDR_W-1:0] ARADDR = '0;
    logic [31:0] WDATA = '0;
    logic [3:0] WSTRB = 4'hF;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic WAKE_EVENT = 1'b0, FLASH_RD_IN = 1'b0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, FLASH_RD_OUT;
    logic [1:0] BRESP, RRESP;
    logic [31:0] RDATA;
    logic FAST_OSC_EN, PLL_EN, SLOW_OSC_EN, ANALOG_REF_EN, REGULATOR_EN;
    logic USB_XCVR_EN, USB_PULLUP_EN, BAUD_DOUBLE, CPU_STOP, CPU_IDLE;
    logic KEYPAD_CLK, CARD_CLK, USB_CLK;
    logic [4:0] PLL_FACTOR;
    logic [31:0] rv;
    logic [1:0] rs;
    int error_cnt = 0;
    int num_checks = 0;

    clock_power_control DUT (
        .SYS_CLK, .RESET_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
        .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
        .RRESP, .RVALID, .RREADY, .WAKE_EVENT, .FLASH_RD_IN, .FLASH_RD_OUT,
        .FAST_OSC_EN, .PLL_EN, .SLOW_OSC_EN, .ANALOG_REF_EN, .REGULATOR_EN,
        .USB_XCVR_EN, .USB_PULLUP_EN, .PLL_FACTOR, .BAUD_DOUBLE, .CPU_STOP,
        .CPU_IDLE, .KEYPAD_CLK, .CARD_CLK, .USB_CLK
    );

    always #10 SYS_CLK = ~SYS_CLK;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The master never assumes a latency; the watchdog alone ends a stuck wait.
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bit aw;
        bit w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge SYS_CLK);
        AWADDR <= {idx, 2'b00};
        WDATA <= {24'h0, d};
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (!(aw && w)) begin
            @(posedge SYS_CLK);
            if (!aw && AWREADY === 1'b1) begin
                aw = 1'b1;
                AWVALID <= 1'b0;
            end
            if (!w && WREADY === 1'b1) begin
                w = 1'b1;
                WVALID <= 1'b0;
            end
        end
        while (BVALID !== 1'b1) @(posedge SYS_CLK);
        rs = BRESP;
        BREADY <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] idx);
        @(posedge SYS_CLK);
        ARADDR <= {idx, 2'b00};
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(posedge SYS_CLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        while (RVALID !== 1'b1) @(posedge SYS_CLK);
        rv = RDATA;
        rs = RRESP;
        RREADY <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check(PLL_FACTOR, 32'd8);
        rd(MASTER_CLOCK_GATING_IDX);
        check(rv, 32'h0A);
        rd(CPU_POWER_MODE_IDX);
        check(rv, 32'h00);
        rd(POWER_OPTIONS_SECOND_IDX);
        check(rv, 32'h10);
        rd(16'h0000);
        check(rs, RESP_SLVERR);
        check(rv, 32'h0);
        wr(16'h0001, 8'hFF);
        check(rs, RESP_SLVERR);
    endtask

    task automatic t_opts();
        wr(POWER_OPTIONS_SECOND_IDX, 8'h07);
        check({ANALOG_REF_EN, REGULATOR_EN, PLL_EN}, 3'b000);
        check({USB_XCVR_EN, USB_PULLUP_EN}, 2'b01);
        wr(POWER_OPTIONS_SECOND_IDX, 8'h00);
        check({ANALOG_REF_EN, REGULATOR_EN, PLL_EN}, 3'b111);
        check({USB_XCVR_EN, USB_PULLUP_EN}, 2'b10);
    endtask

    task automatic t_clocks();
        for (int m = 0; m < 8; m++) begin
            wr(MASTER_CLOCK_GATING_IDX, {5'b00001, m[2:0]});
            check(PLL_FACTOR, 2 * m + 4);
        end
        check(SLOW_OSC_EN, 1'b0);
        wr(MASTER_CLOCK_GATING_IDX, 8'h82);
        check({FAST_OSC_EN, PLL_EN, SLOW_OSC_EN}, 3'b001);
        for (int k = 0; k < 8; k++) begin
            wr(MASTER_CLOCK_GATING_IDX, {1'b0, k[2:0], 4'h2});
            #5;
            check({KEYPAD_CLK, CARD_CLK, USB_CLK}, {~k[2], ~k[1], ~k[0]});
            #10;
            check({KEYPAD_CLK, CARD_CLK, USB_CLK}, 3'b000);
        end
        check({FAST_OSC_EN, PLL_EN}, 2'b11);
    endtask

    task automatic t_flash(input logic [7:0] opts, input int len, input int exp);
        int cnt;
        cnt = 0;
        wr(POWER_OPTIONS_SECOND_IDX, opts);
        FLASH_RD_IN <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            @(posedge SYS_CLK);
            if (i == len - 1) begin
                FLASH_RD_IN <= 1'b0;
            end
            cnt += (FLASH_RD_OUT === 1'b1) ? 1 : 0;
        end
        check(cnt, exp);
    endtask

    task automatic t_cpu();
        wr(CPU_POWER_MODE_IDX, 8'hFF);
        rd(CPU_POWER_MODE_IDX);
        check(rv, 32'h8F);
        check({BAUD_DOUBLE, CPU_STOP, CPU_IDLE}, 3'b111);
        wr(CPU_POWER_MODE_IDX, 8'h0C);
        rd(CPU_POWER_MODE_IDX);
        check(rv, 32'h0C);
        check({BAUD_DOUBLE, CPU_STOP, CPU_IDLE}, 3'b000);
        wr(CPU_POWER_MODE_IDX, 8'h01);
        check({BAUD_DOUBLE, CPU_STOP, CPU_IDLE}, 3'b001);
        WSTRB <= 4'hE;
        wr(CPU_POWER_MODE_IDX, 8'h0C);
        WSTRB <= 4'hF;
        check(rs, RESP_OKAY);
        rd(CPU_POWER_MODE_IDX);
        check(rv, 32'h01);
    endtask

    task automatic t_pd();
        int n;
        wr(MASTER_CLOCK_GATING_IDX, 8'h02);
        wr(CPU_POWER_MODE_IDX, 8'h03);
        wr(POWER_OPTIONS_FIRST_IDX, 8'h80);
        n = 1;
        while (FAST_OSC_EN === 1'b1 && n < 40) begin
            @(posedge SYS_CLK);
            n++;
        end
        check(n, 33);
        check({FAST_OSC_EN, PLL_EN, SLOW_OSC_EN}, 3'b001);
        #5;
        check({KEYPAD_CLK, CARD_CLK, USB_CLK}, 3'b000);
        rd(MASTER_CLOCK_GATING_IDX);
        check(rv, 32'h02);
        @(posedge SYS_CLK);
        WAKE_EVENT <= 1'b1;
        @(posedge SYS_CLK);
        WAKE_EVENT <= 1'b0;
        @(posedge SYS_CLK);
        check({FAST_OSC_EN, PLL_EN, CPU_STOP, CPU_IDLE}, 4'b1100);
        #5;
        check({KEYPAD_CLK, CARD_CLK, USB_CLK}, 3'b111);
    endtask

    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        t_reset();
        t_opts();
        t_clocks();
        t_flash(8'h20, 5, 5);
        t_flash(8'h30, 5, 5);
        t_flash(8'h00, 5, 2);
        t_flash(8'h10, 5, 3);
        t_flash(8'h10, 1, 1);
        t_cpu();
        t_pd();
        results();
    end

    // The whole run needs well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        error_cnt++;
        results();
    end
endmodule
